//--- inc/hms_regs.svh
/*
 * Register offsets, field positions, reset values and cycle counts of the
 * halt mode sequencer.
 * Assumes a 32-bit APB with byte addresses, one aligned word per register.
 */
`ifndef HMS_REGS_SVH
`define HMS_REGS_SVH

`define HMS_ADDR_MAIN_CLK       8'h00
`define HMS_ADDR_AWU_CS         8'h04
`define HMS_ADDR_AWU_PRESC      8'h08
`define HMS_ADDR_OPTION         8'h0C
`define HMS_ADDR_STATUS         8'h10

`define HMS_BIT_RTC_IRQ_EN      0
`define HMS_BIT_AWU_EN          0
`define HMS_BIT_AWU_MEAS        1
`define HMS_BIT_AWU_FLAG        2
`define HMS_BIT_OPT_LONG        0
`define HMS_BIT_OPT_WDG         1

`define HMS_PRESC_RESET         8'hFF
`define HMS_PRESC_ZERO          8'h00
`define HMS_OPT_LONG_RESET      1'b1
`define HMS_OPT_WDG_RESET       1'b0

`define HMS_HALT_OPCODE         8'h8E
`define HMS_MASK_ENABLED        2'h2

`define HMS_STAB_SHORT          13'h0100
`define HMS_STAB_LONG           13'h1000
`define HMS_CNT_ONE             13'h0001

`define HMS_AWU_DIV_LAST        6'h3F
`define HMS_RC_STRT_TICKS       4'h4
`define HMS_PRESC_ONE           8'h01

`endif

//--- inc/hms_pkg.sv
/*
 * Types shared by the halt mode sequencer and its wake-up timer.
 * Assumes hms_regs.svh supplies the numeric constants.
 */
package hms_pkg;

    typedef enum logic [2:0] {
        HMS_RUN    = 3'b000,
        HMS_HALT   = 3'b001,
        HMS_AHALT  = 3'b010,
        HMS_AWHALT = 3'b011,
        HMS_STAB   = 3'b100
    } hms_state_t;

    typedef enum logic [1:0] {
        HMS_AWU_IDLE  = 2'b00,
        HMS_AWU_START = 2'b01,
        HMS_AWU_COUNT = 2'b10,
        HMS_AWU_DONE  = 2'b11
    } hms_awu_state_t;

endpackage : hms_pkg

//--- inc/hms_awu_if.sv
/*
 * Link between the sequencer and its auto wake-up timer.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/1ps

interface hms_awu_if;
    logic       run;
    logic       measure;
    logic [7:0] prescaler;
    logic       rc_tick;
    logic       expired;
    logic       rc_on;
    logic       capture;

    modport ctrl  (output run, output measure, output prescaler, output rc_tick,
                   input expired, input rc_on, input capture);
    modport timer (input run, input measure, input prescaler, input rc_tick,
                   output expired, output rc_on, output capture);
endinterface : hms_awu_if

//--- src/hms_awu.sv
/*
 * Auto wake-up timer: RC start-up wait, fixed divide by 64, then the
 * programmable prescaler; also the measurement route to the timer capture.
 * Assumes rc_tick is a one-cycle pulse per RC period, synchronous to pclk.
 */
`timescale 1ns/1ps
`include "hms_regs.svh"

module hms_awu (
    input  wire logic pclk,
    input  wire logic presetn,
    hms_awu_if.timer  awu
);
    import hms_pkg::*;

    typedef struct packed {
        hms_awu_state_t st;
        logic [3:0]     strt;
        logic [5:0]     div;
        logic [7:0]     presc;
        logic           expired;
        logic           rc_on;
        logic           capture;
    } hms_awu_regs_t;

    hms_awu_regs_t s;
    hms_awu_regs_t next_s;

    always_comb begin
        next_s = s;
        next_s.expired = 1'b0;
        case (s.st)
            HMS_AWU_IDLE: begin
                if (awu.run) begin
                    next_s.st   = HMS_AWU_START;
                    next_s.strt = `HMS_RC_STRT_TICKS;
                end
            end
            HMS_AWU_START: begin
                if (awu.rc_tick) begin
                    next_s.strt = s.strt - 4'h1;
                    if (s.strt == 4'h1) begin
                        next_s.st    = HMS_AWU_COUNT;
                        next_s.div   = 6'h00;
                        next_s.presc = awu.prescaler;
                    end
                end
            end
            HMS_AWU_COUNT: begin
                if (awu.rc_tick) begin
                    next_s.div = s.div + 6'h01;
                    if (s.div == `HMS_AWU_DIV_LAST) begin
                        next_s.presc = s.presc - 8'h01;
                        if (s.presc == `HMS_PRESC_ONE) begin
                            next_s.st      = HMS_AWU_DONE;
                            next_s.expired = 1'b1;
                        end
                    end
                end
            end
            HMS_AWU_DONE: begin
                next_s.st = HMS_AWU_DONE;
            end
            default: next_s.st = HMS_AWU_IDLE;
        endcase
        if (!awu.run) begin
            next_s.st = HMS_AWU_IDLE;
        end
        next_s.rc_on   = (next_s.st != HMS_AWU_IDLE) | awu.measure;
        next_s.capture = awu.measure & awu.rc_tick;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign awu.expired = s.expired;
    assign awu.rc_on   = s.rc_on;
    assign awu.capture = s.capture;

endmodule : hms_awu

//--- src/hms_top.sv
/*
 * Halt mode sequencer: stop mode choice, clock gating, wake-up and
 * oscillator stabilisation, APB registers and the auto wake-up timer.
 * Assumes the CPU core pulses opcode_valid with each fetched opcode and
 * obeys cpu_hold, mask_force and the resume pulses.
 */
// Chosen here: register access over APB and the address map.
// How it works
// - Halt with both enables clear: plain halt.
// - Halt with RTC interrupt enabled: active halt.
// - Halt with only auto wake-up enabled: wake-up halt.
// - Wake restarts oscillator, holds CPU 256/4096.
// - After wait, resume interrupt or reset vector.
// - Entry forces mask to 10b; pending wakes.
// - Plain/wake-up halt stop oscillator and peripherals.
// - Watchdog option may turn halt into reset.
// - Active halt keeps oscillator and RTC counter.
// - Active halt exit; wait only after reset.
// - Active halt never gives watchdog reset.
// - Wake-up halt starts RC oscillator and prescaler.
// - Expiry sets flag, interrupts, stabilises, services.
// - AWU control/status read clears flag and request.
// - Measure bit routes RC clock to capture.
// - Wake-up halt exits like plain halt.
// - Opcode 8E is the halt instruction.
// - Delay is 64 times prescaler plus start-up.
// - Prescaler resets to all ones.
// - Zero prescaler write is ignored.
`timescale 1ns/1ps
`include "hms_regs.svh"

module hms_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  opcode,
    input  wire logic        opcode_valid,
    input  wire logic        wake_irq,
    input  wire logic        rtc_irq,
    input  wire logic        wake_reset,
    input  wire logic        watchdog_enabled,
    input  wire logic        rc_tick,
    output hms_pkg::hms_state_t mode,
    output logic             cpu_hold,
    output logic             main_osc_on,
    output logic             periph_clk_en,
    output logic             rtc_counter_clk_en,
    output logic             mask_force,
    output logic [1:0]       interrupt_mask_bits,
    output logic             watchdog_reset_req,
    output logic             autowake_irq,
    output logic             resume_irq,
    output logic             resume_reset_vector,
    output logic             rc_osc_on,
    output logic             timer_capture_input_one
);
    import hms_pkg::*;

    typedef struct packed {
        hms_state_t  st;
        logic [12:0] cnt;
        logic        by_reset;
        logic        rtc_irq_enable;
        logic        autowake_enable;
        logic        autowake_measure;
        logic        autowake_flag;
        logic [7:0]  autowake_prescaler;
        logic        opt_long;
        logic        watchdog_halt_option;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        cpu_hold;
        logic        main_osc_on;
        logic        periph_clk_en;
        logic        rtc_counter_clk_en;
        logic        mask_force;
        logic [1:0]  mask_bits;
        logic        wdg_rst;
        logic        res_irq;
        logic        res_rst;
        logic        rc_osc_on;
        logic        capture;
    } hms_regs_t;

    hms_regs_t s;
    hms_regs_t next_s;
    hms_awu_if awu ();

    function automatic logic [12:0] stab_len(input logic long_wait);
        stab_len = long_wait ? `HMS_STAB_LONG : `HMS_STAB_SHORT;
    endfunction : stab_len

    logic setup;
    logic wr_done;
    logic rd_clr;
    logic halt_fetch;
    logic wdg_blocks;

    assign setup      = psel & ~penable;
    assign wr_done    = psel & penable & s.pready & pwrite & ~s.pslverr;
    assign rd_clr     = psel & penable & s.pready & ~pwrite
                        & (paddr == `HMS_ADDR_AWU_CS);
    assign halt_fetch = opcode_valid & (opcode == `HMS_HALT_OPCODE);
    assign wdg_blocks = watchdog_enabled & ~s.rtc_irq_enable
                        & ~s.watchdog_halt_option;

    assign awu.run       = (s.st == HMS_AWHALT);
    assign awu.measure   = s.autowake_measure & (s.st == HMS_RUN);
    assign awu.prescaler = s.autowake_prescaler;
    assign awu.rc_tick   = rc_tick;

    hms_awu u_awu (
        .pclk    (pclk),
        .presetn (presetn),
        .awu     (awu.timer)
    );

    always_comb begin
        next_s = s;
        next_s.mask_force = 1'b0;
        next_s.wdg_rst    = 1'b0;
        next_s.res_irq    = 1'b0;
        next_s.res_rst    = 1'b0;
        next_s.pready     = 1'b0;
        next_s.pslverr    = 1'b0;
        // APB: answer one cycle after setup
        if (setup) begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0000_0000;
            case (paddr)
                `HMS_ADDR_MAIN_CLK:
                    next_s.prdata[`HMS_BIT_RTC_IRQ_EN] = s.rtc_irq_enable;
                `HMS_ADDR_AWU_CS: begin
                    next_s.prdata[`HMS_BIT_AWU_EN]   = s.autowake_enable;
                    next_s.prdata[`HMS_BIT_AWU_MEAS] = s.autowake_measure;
                    next_s.prdata[`HMS_BIT_AWU_FLAG] = s.autowake_flag | awu.expired;
                end
                `HMS_ADDR_AWU_PRESC:
                    next_s.prdata[7:0] = s.autowake_prescaler;
                `HMS_ADDR_OPTION: begin
                    next_s.prdata[`HMS_BIT_OPT_LONG] = s.opt_long;
                    next_s.prdata[`HMS_BIT_OPT_WDG]  = s.watchdog_halt_option;
                end
                `HMS_ADDR_STATUS:
                    next_s.prdata[2:0] = s.st;
                default:
                    next_s.pslverr = 1'b1;
            endcase
        end
        if (wr_done) begin
            case (paddr)
                `HMS_ADDR_MAIN_CLK:
                    next_s.rtc_irq_enable = pwdata[`HMS_BIT_RTC_IRQ_EN];
                `HMS_ADDR_AWU_CS: begin
                    next_s.autowake_enable  = pwdata[`HMS_BIT_AWU_EN];
                    next_s.autowake_measure = pwdata[`HMS_BIT_AWU_MEAS];
                end
                `HMS_ADDR_AWU_PRESC: begin
                    if (pwdata[7:0] != `HMS_PRESC_ZERO) begin
                        next_s.autowake_prescaler = pwdata[7:0];
                    end
                end
                `HMS_ADDR_OPTION: begin
                    next_s.opt_long             = pwdata[`HMS_BIT_OPT_LONG];
                    next_s.watchdog_halt_option = pwdata[`HMS_BIT_OPT_WDG];
                end
                default: next_s.opt_long = s.opt_long;
            endcase
        end
        // Flag: expiry wins over the clearing read
        next_s.autowake_flag = (s.autowake_flag & ~rd_clr) | awu.expired;
        // Mode sequencing
        case (s.st)
            HMS_RUN: begin
                if (halt_fetch) begin
                    if (wdg_blocks) begin
                        next_s.wdg_rst = 1'b1;
                    end else begin
                        next_s.mask_force = 1'b1;
                        next_s.mask_bits  = `HMS_MASK_ENABLED;
                        if (s.rtc_irq_enable) begin
                            next_s.st = HMS_AHALT;
                        end else if (s.autowake_enable) begin
                            next_s.st = HMS_AWHALT;
                        end else begin
                            next_s.st = HMS_HALT;
                        end
                    end
                end
            end
            HMS_HALT, HMS_AWHALT: begin
                if (wake_reset) begin
                    next_s.st       = HMS_STAB;
                    next_s.by_reset = 1'b1;
                    next_s.cnt      = stab_len(s.opt_long);
                end else if (wake_irq | s.autowake_flag | awu.expired) begin
                    next_s.st       = HMS_STAB;
                    next_s.by_reset = 1'b0;
                    next_s.cnt      = stab_len(s.opt_long);
                end
            end
            HMS_AHALT: begin
                if (wake_reset) begin
                    next_s.st       = HMS_STAB;
                    next_s.by_reset = 1'b1;
                    next_s.cnt      = stab_len(s.opt_long);
                end else if (wake_irq | rtc_irq | s.autowake_flag) begin
                    next_s.st      = HMS_RUN;
                    next_s.res_irq = 1'b1;
                end
            end
            HMS_STAB: begin
                next_s.cnt = s.cnt - `HMS_CNT_ONE;
                if (s.cnt == `HMS_CNT_ONE) begin
                    next_s.st      = HMS_RUN;
                    next_s.res_irq = ~s.by_reset;
                    next_s.res_rst = s.by_reset;
                end
            end
            default: next_s.st = HMS_RUN;
        endcase
        // Main clock gating follows the coming state; rc_osc_on and capture copy the timer outputs
        next_s.cpu_hold           = (next_s.st != HMS_RUN);
        next_s.main_osc_on        = (next_s.st != HMS_HALT)
                                    & (next_s.st != HMS_AWHALT);
        next_s.periph_clk_en      = (next_s.st == HMS_RUN);
        next_s.rtc_counter_clk_en = (next_s.st == HMS_RUN)
                                    | (next_s.st == HMS_AHALT);
        next_s.rc_osc_on          = awu.rc_on;
        next_s.capture            = awu.capture;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s                      <= '0;
            s.autowake_prescaler   <= `HMS_PRESC_RESET;
            s.opt_long             <= `HMS_OPT_LONG_RESET;
            s.watchdog_halt_option <= `HMS_OPT_WDG_RESET;
            s.main_osc_on          <= 1'b1;
            s.periph_clk_en        <= 1'b1;
            s.rtc_counter_clk_en   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata                  = s.prdata;
    assign pready                  = s.pready;
    assign pslverr                 = s.pslverr;
    assign mode                    = s.st;
    assign cpu_hold                = s.cpu_hold;
    assign main_osc_on             = s.main_osc_on;
    assign periph_clk_en           = s.periph_clk_en;
    assign rtc_counter_clk_en      = s.rtc_counter_clk_en;
    assign mask_force              = s.mask_force;
    assign interrupt_mask_bits     = s.mask_bits;
    assign watchdog_reset_req      = s.wdg_rst;
    assign autowake_irq            = s.autowake_flag;
    assign resume_irq              = s.res_irq;
    assign resume_reset_vector     = s.res_rst;
    assign rc_osc_on               = s.rc_osc_on;
    assign timer_capture_input_one = s.capture;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic run_halt;
    assign run_halt = (s.st == HMS_RUN) & halt_fetch & ~wdg_blocks;

    sequence s_halt_wake_reset;
        ((s.st == HMS_HALT) || (s.st == HMS_AWHALT)) && wake_reset;
    endsequence
    sequence s_stab_started;
        (s.st == HMS_STAB) && main_osc_on && cpu_hold
        && (s.cnt == stab_len(s.opt_long));
    endsequence

    a_plain_halt_entry: assert property (run_halt && !s.rtc_irq_enable
        && !s.autowake_enable |=> mode == HMS_HALT && !main_osc_on)
        else $error("plain halt not entered");
    a_active_entry: assert property (run_halt && s.rtc_irq_enable
        |=> mode == HMS_AHALT && rtc_counter_clk_en && !periph_clk_en)
        else $error("active halt not entered");
    a_autowake_entry: assert property (run_halt && !s.rtc_irq_enable
        && s.autowake_enable |=> mode == HMS_AWHALT ##2 rc_osc_on)
        else $error("wake-up halt not entered");
    a_mask_forced: assert property (run_halt
        |=> mask_force && interrupt_mask_bits == `HMS_MASK_ENABLED)
        else $error("mask not forced on entry");
    a_wake_stab: assert property (s_halt_wake_reset |=> s_stab_started)
        else $error("stabilisation wait not started");
    a_stab_resume: assert property ((s.st == HMS_STAB) && (s.cnt == `HMS_CNT_ONE)
        |=> !cpu_hold && (resume_irq ^ resume_reset_vector))
        else $error("no resume after wait");
    a_wdg_halt: assert property ((s.st == HMS_RUN) && halt_fetch && wdg_blocks
        |=> watchdog_reset_req && mode == HMS_RUN)
        else $error("watchdog reset not raised");
    a_active_no_wdg: assert property ((s.st == HMS_RUN) && halt_fetch
        && s.rtc_irq_enable |=> !watchdog_reset_req)
        else $error("watchdog reset from active halt");
    a_active_fast_exit: assert property ((s.st == HMS_AHALT) && !wake_reset && rtc_irq
        |=> resume_irq && mode == HMS_RUN)
        else $error("active halt exit delayed");
    a_flag_hold: assert property (autowake_irq && !rd_clr |=> autowake_irq)
        else $error("wake-up request dropped");
    a_flag_clear: assert property (autowake_irq && rd_clr && !awu.expired
        |=> !autowake_irq)
        else $error("read did not clear flag");
    a_presc_nonzero: assert property (s.autowake_prescaler != `HMS_PRESC_ZERO)
        else $error("prescaler became zero");

endmodule : hms_top

//--- verification/hms_cpu_model.sv
/*
 * Stand-in for the CPU core: fetches opcodes with a one-cycle valid.
 * Assumes the sequencer holds cpu_hold high while the core is stopped.
 */
`timescale 1ns/1ps

module hms_cpu_model (
    input  wire logic  pclk,
    input  wire logic  cpu_hold,
    output logic [7:0] opcode,
    output logic       opcode_valid
);
    initial begin
        opcode       = 8'h00;
        opcode_valid = 1'b0;
    end

    // No fetch while held, for up to 100 cycles; opcode line changes once released
    task automatic fetch(input logic [7:0] op);
        int i;
        for (i = 0; i < 100 && cpu_hold !== 1'b0; i++) @(posedge pclk);
        @(posedge pclk);
        opcode       <= op;
        opcode_valid <= 1'b1;
        @(posedge pclk);
        opcode_valid <= 1'b0;
        opcode       <= ~op;
    endtask : fetch
endmodule : hms_cpu_model

//--- verification/hms_top_test.sv
/*
 * Self-checking bench of the halt mode sequencer.
 * Assumes the CPU stand-in model and a 50 MHz pclk.
 */
`timescale 1ns/1ps
`include "hms_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end

module hms_top_test;
    import hms_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, err, wake_irq = 0, rtc_irq = 0, wake_reset = 0;
    logic watchdog_enabled = 0, rc_tick = 0, opcode_valid;
    logic [7:0] opcode;
    hms_state_t mode;
    logic cpu_hold, main_osc_on, periph_clk_en, rtc_counter_clk_en, mask_force;
    logic [1:0] interrupt_mask_bits;
    logic watchdog_reset_req, autowake_irq, resume_irq, resume_reset_vector;
    logic rc_osc_on, timer_capture_input_one;
    int n_errors = 0, total_checks = 0, k;

    hms_top i_hms_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .opcode(opcode), .opcode_valid(opcode_valid),
        .wake_irq(wake_irq), .rtc_irq(rtc_irq), .wake_reset(wake_reset),
        .watchdog_enabled(watchdog_enabled), .rc_tick(rc_tick), .mode(mode),
        .cpu_hold(cpu_hold), .main_osc_on(main_osc_on), .periph_clk_en(periph_clk_en),
        .rtc_counter_clk_en(rtc_counter_clk_en), .mask_force(mask_force),
        .interrupt_mask_bits(interrupt_mask_bits), .watchdog_reset_req(watchdog_reset_req),
        .autowake_irq(autowake_irq), .resume_irq(resume_irq),
        .resume_reset_vector(resume_reset_vector), .rc_osc_on(rc_osc_on),
        .timer_capture_input_one(timer_capture_input_one));
    hms_cpu_model i_hms_cpu_model (.pclk(pclk), .cpu_hold(cpu_hold), .opcode(opcode),
        .opcode_valid(opcode_valid));

    initial begin
        forever #10 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic timeout();
        n_errors++;
        $display("ERROR %0t wait limit", $time);
        summarize();
    endtask : timeout

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout();
        r = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb

    // Raises one wake cause: reset event or plain interrupt
    task automatic wake(input logic by_rst);
        wake_reset <= by_rst;
        wake_irq   <= ~by_rst;
    endtask : wake

    // Waits for stabilisation, counts its cycles, checks the resume kind
    task automatic stab(input int n, input logic rv);
        int c;
        for (c = 0; c < 300 && mode !== HMS_STAB; c++) @(posedge pclk);
        if (c == 300) timeout();
        `CHK(main_osc_on, 1'b1)
        wake_irq <= 0; wake_reset <= 0;
        for (c = 1; c < 5000; c++) begin
            @(posedge pclk);
            if (mode !== HMS_STAB) break;
        end
        `CHK(c, n)
        `CHK(mode, HMS_RUN)
        `CHK(cpu_hold, 1'b0)
        `CHK(resume_irq, !rv)
        `CHK(resume_reset_vector, rv)
    endtask : stab

    task automatic t_plain();
        apb(1, `HMS_ADDR_OPTION, 32'h0000_0000);
        i_hms_cpu_model.fetch(8'h8F);
        repeat (2) @(posedge pclk);
        `CHK(mode, HMS_RUN)
        i_hms_cpu_model.fetch(8'h8E);
        @(posedge pclk);
        `CHK(mode, HMS_HALT)
        `CHK(cpu_hold, 1'b1)
        `CHK(mask_force, 1'b1)
        `CHK(interrupt_mask_bits, 2'h2)
        `CHK({main_osc_on, periph_clk_en}, 2'h0)
        wake(1'b0);
        stab(256, 0);
        apb(1, `HMS_ADDR_OPTION, 32'h0000_0001);
        i_hms_cpu_model.fetch(8'h8E);
        wake(1'b1);
        stab(4096, 1);
        $display("plain halt done");
    endtask : t_plain

    task automatic t_active();
        apb(1, `HMS_ADDR_OPTION, 32'h0000_0000);
        apb(1, `HMS_ADDR_MAIN_CLK, 32'h0000_0001);
        watchdog_enabled <= 1;
        i_hms_cpu_model.fetch(8'h8E);
        @(posedge pclk);
        `CHK(mode, HMS_AHALT)
        `CHK(watchdog_reset_req, 1'b0)
        `CHK({main_osc_on, rtc_counter_clk_en, periph_clk_en}, 3'h6)
        rtc_irq <= 1;
        repeat (2) @(posedge pclk);
        `CHK(mode, HMS_RUN)
        `CHK(resume_irq, 1'b1)
        rtc_irq <= 0;
        apb(1, `HMS_ADDR_MAIN_CLK, 32'h0000_0000);
        i_hms_cpu_model.fetch(8'h8E);
        @(posedge pclk);
        `CHK(watchdog_reset_req, 1'b1)
        `CHK(mode, HMS_RUN)
        apb(1, `HMS_ADDR_OPTION, 32'h0000_0002);
        i_hms_cpu_model.fetch(8'h8E);
        @(posedge pclk);
        `CHK(mode, HMS_HALT)
        `CHK(watchdog_reset_req, 1'b0)
        wake(1'b0);
        stab(256, 0);
        watchdog_enabled <= 0;
        apb(1, `HMS_ADDR_MAIN_CLK, 32'h0000_0001);
        i_hms_cpu_model.fetch(8'h8E);
        wake(1'b1);
        stab(256, 1);
        apb(1, `HMS_ADDR_MAIN_CLK, 32'h0000_0000);
        $display("active halt done");
    endtask : t_active

    task automatic t_awu();
        apb(0, `HMS_ADDR_AWU_PRESC, 0);
        `CHK(r, 32'h0000_00FF)
        apb(1, `HMS_ADDR_AWU_PRESC, 0);
        apb(0, `HMS_ADDR_AWU_PRESC, 0);
        `CHK(r, 32'h0000_00FF)
        apb(1, `HMS_ADDR_AWU_PRESC, 32'h0000_0001);
        apb(1, `HMS_ADDR_AWU_CS, 32'h0000_0001);
        i_hms_cpu_model.fetch(8'h8E);
        @(posedge pclk);
        `CHK(mode, HMS_AWHALT)
        `CHK(main_osc_on, 1'b0)
        repeat (3) @(posedge pclk);
        `CHK(rc_osc_on, 1'b1)
        for (k = 1; k < 200; k++) begin
            rc_tick <= 1;
            @(posedge pclk);
            rc_tick <= 0;
            repeat (2) @(posedge pclk);
            if (autowake_irq === 1'b1) break;
            @(posedge pclk);
        end
        `CHK(k, 68)
        stab(256, 0);
        `CHK(autowake_irq, 1'b1)
        apb(0, `HMS_ADDR_AWU_CS, 0);
        `CHK(r[2], 1'b1)
        @(posedge pclk);
        `CHK(autowake_irq, 1'b0)
        apb(1, `HMS_ADDR_AWU_CS, 32'h0000_0002);
        rc_tick <= 1;
        @(posedge pclk);
        rc_tick <= 0;
        repeat (2) @(posedge pclk);
        `CHK(timer_capture_input_one, 1'b1)
        `CHK(rc_osc_on, 1'b1)
        apb(1, `HMS_ADDR_AWU_CS, 0);
        apb(0, 8'h20, 0);
        `CHK(err, 1'b1)
        $display("auto wake-up done");
    endtask : t_awu

    // Reset while in active halt: state and registers return to defaults
    task automatic t_reset();
        apb(1, `HMS_ADDR_AWU_PRESC, 32'h0000_0010);
        apb(1, `HMS_ADDR_MAIN_CLK, 32'h0000_0001);
        i_hms_cpu_model.fetch(8'h8E);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        `CHK(mode, HMS_RUN)
        `CHK({cpu_hold, main_osc_on}, 2'h1)
        apb(0, `HMS_ADDR_AWU_PRESC, 0);
        `CHK(r, 32'h0000_00FF)
        apb(0, `HMS_ADDR_MAIN_CLK, 0);
        `CHK(r, 32'h0000_0000)
        $display("mid-run reset done");
    endtask : t_reset

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        `CHK(main_osc_on, 1'b1)
        t_plain();
        t_active();
        t_awu();
        t_reset();
        summarize();
    end
endmodule : hms_top_test
